// [hw/lsbui_core.sv]
// How it works
// - powers up in stand-by, clock halted, log empty
// - idle runs clock, waits reader or button start
// - active takes samples at interval, optional store
// - logging end enters sleep, log kept till reset
// - interval 1 s to 18 h, 3958 samples max
// - sixteen range alarms feed the alarm summary
// - enable bit clear means button checks status only
// - press under two seconds shows status
// - good battery no alarm: green two seconds
// - good battery any alarm: red two seconds
// - low battery blinks same colour two seconds
// - start offer needs repress within five seconds
// - confirmed start lights green fifteen seconds
// - stop offer needs repress within five seconds
// - confirmed stop lights red fifteen seconds
`timescale 1ns/1ps
`default_nettype none
`include "lsbui_defines.svh"
module lsbui_core #(
  parameter int SHORT_CYC   = `LSBUI_SHORT_MS * `LSBUI_MS_CYC,
  parameter int STATUS_CYC  = `LSBUI_STATUS_MS * `LSBUI_MS_CYC,
  parameter int CONFIRM_CYC = `LSBUI_CONFIRM_MS * `LSBUI_MS_CYC,
  parameter int ACK_CYC     = `LSBUI_ACK_MS * `LSBUI_MS_CYC,
  parameter int BLINK_CYC   = `LSBUI_BLINK_MS * `LSBUI_MS_CYC,
  parameter int SEC_CYC     = `LSBUI_CLK_HZ,
  parameter int LOG_DEPTH   = `LSBUI_LOG_DEPTH,
  parameter int NUM_RANGES  = `LSBUI_NUM_RANGES
) (
  // clock and reset
  input  wire  logic                  clk_sys,
  input  wire  logic                  rstn,
  // avalon-mm slave
  input  wire  logic [5:0]            avs_address,
  input  wire  logic                  avs_read,
  input  wire  logic                  avs_write,
  input  wire  logic [31:0]           avs_writedata,
  input  wire  logic [3:0]            avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // manual interface
  input  wire  logic                  button,
  output logic                        led_green,
  output logic                        led_red,
  // alarm and battery inputs
  input  wire  logic                  memory_full_flag,
  input  wire  logic                  arrival_time_alarm,
  input  wire  logic                  bin_counter_alarm,
  input  wire  logic                  kinetic_temp_alarm,
  input  wire  logic                  shelf_life_alarm,
  input  wire  logic [NUM_RANGES-1:0] range_alarm,
  input  wire  logic                  battery_low,
  // reader commands
  input  wire  logic                  reader_start,
  input  wire  logic                  reader_reset,
  // logging side
  output logic                        clock_run,
  output logic                        sample_take,
  output logic                        sample_store,
  output logic [1:0]                  op_state,
  output logic                        irq
);
  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  lsbui_pkg::lsbui_op_t  op, next_op;           // operating state
  lsbui_pkg::lsbui_btn_t bst;                   // button phase
  lsbui_pkg::lsbui_led_t lmode;                 // led display mode
  logic [31:0] ctrl;                            // control word
  logic [31:0] interval;                        // sampling interval, seconds
  logic [31:0] tmr;                             // button / led timer
  logic [31:0] ltmr;                            // led display timer
  logic [31:0] sec_cnt;                         // cycles within one second
  logic [31:0] int_cnt;                         // seconds within interval
  logic [31:0] blink_cnt;                       // blink half period count
  logic [15:0] nsamp;                           // samples stored
  logic [`LSBUI_IRQ_W-1:0] irq_stat, irq_mask;  // interrupt bits
  logic        btn_q;                           // button one cycle late
  logic        blink;                           // blink phase
  logic        snap_alarm, snap_low;            // status snapshot
  logic        offer_stop;                      // offer is for stop
  logic        acc_d;                           // bus accepted last cycle
  // -------------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------------
  wire [3:0] widx      = avs_address[5:2];
  wire       wr_hit    = avs_write && !avs_waitrequest;
  wire       rd_hit    = avs_read && !avs_waitrequest;
  wire       w_ctrl    = wr_hit && widx == `LSBUI_REG_CTRL && avs_byteenable[0];
  wire       w_int     = wr_hit && widx == `LSBUI_REG_INTERVAL;
  wire       w_stat    = wr_hit && widx == `LSBUI_REG_IRQ_STAT && avs_byteenable[0];
  wire       w_mask    = wr_hit && widx == `LSBUI_REG_IRQ_MASK && avs_byteenable[0];
  wire       w_cmd     = wr_hit && widx == `LSBUI_REG_CMD && avs_byteenable[0];
  wire       bse       = ctrl[`LSBUI_CTRL_BSE];
  wire       stop_dis  = ctrl[`LSBUI_CTRL_STOPDIS];
  wire       any_alarm = memory_full_flag | arrival_time_alarm | bin_counter_alarm
                       | kinetic_temp_alarm | shelf_life_alarm | (|range_alarm);
  wire       press     = button && !btn_q;
  wire       release_e = !button && btn_q;
  wire       long_ok   = bse && (op == lsbui_pkg::LSBUI_IDLE
                       || (op == lsbui_pkg::LSBUI_ACTIVE && !stop_dis));
  wire       confirm   = bst == lsbui_pkg::LSBUI_B_WAIT && press;
  wire       btn_start = confirm && !offer_stop && op == lsbui_pkg::LSBUI_IDLE;
  wire       btn_stop  = confirm && offer_stop && op == lsbui_pkg::LSBUI_ACTIVE;
  wire       cmd_start = w_cmd && avs_writedata[`LSBUI_CMD_START];
  wire       cmd_stop  = w_cmd && avs_writedata[`LSBUI_CMD_STOP];
  wire       cmd_reset = (w_cmd && avs_writedata[`LSBUI_CMD_RESET]) || reader_reset;
  wire       mem_full  = nsamp == 16'(LOG_DEPTH);
  wire       tick_sec  = sec_cnt == 32'(SEC_CYC - 1);
  wire       tick_smp  = tick_sec && int_cnt + 32'd1 >= interval;
  wire       do_sample = op == lsbui_pkg::LSBUI_ACTIVE && tick_smp;
  wire       stop_any  = op == lsbui_pkg::LSBUI_ACTIVE && (btn_stop || cmd_stop
                       || (do_sample && mem_full));
  wire       start_any = op == lsbui_pkg::LSBUI_IDLE && (btn_start || cmd_start
                       || reader_start);
  wire [31:0] clamp_int = avs_writedata < 32'd`LSBUI_INTERVAL_MIN_S ? 32'd`LSBUI_INTERVAL_MIN_S
                        : avs_writedata > 32'd`LSBUI_INTERVAL_MAX_S ? 32'd`LSBUI_INTERVAL_MAX_S
                        : avs_writedata;
  wire [`LSBUI_IRQ_W-1:0] ev = {do_sample && mem_full,
                                do_sample && ctrl[`LSBUI_CTRL_STORE] && !mem_full,
                                stop_any, start_any};
  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (widx)
      `LSBUI_REG_CTRL:      rd_mux = ctrl;
      `LSBUI_REG_STATE:     rd_mux = {30'h0000_0000, op};
      `LSBUI_REG_INTERVAL:  rd_mux = interval;
      `LSBUI_REG_COUNT:     rd_mux = {16'h0000, nsamp};
      `LSBUI_REG_IRQ_STAT:  rd_mux = {28'h000_0000, irq_stat};
      `LSBUI_REG_IRQ_MASK:  rd_mux = {28'h000_0000, irq_mask};
      `LSBUI_REG_RANGE_ALM: rd_mux = 32'(range_alarm);
      default:              rd_mux = 32'h0000_0000;
    endcase
  end
  // -------------------------------------------------------------------------
  // operating state
  // -------------------------------------------------------------------------
  always_comb begin
    next_op = op;
    case (op)
      lsbui_pkg::LSBUI_STANDBY: if (cmd_start || reader_start) next_op = lsbui_pkg::LSBUI_IDLE;
      lsbui_pkg::LSBUI_IDLE:    if (start_any) next_op = lsbui_pkg::LSBUI_ACTIVE;
      lsbui_pkg::LSBUI_ACTIVE:  if (stop_any) next_op = lsbui_pkg::LSBUI_SLEEP;
      lsbui_pkg::LSBUI_SLEEP:   next_op = op;
      default:                  next_op = lsbui_pkg::LSBUI_STANDBY;
    endcase
    if (cmd_reset) next_op = lsbui_pkg::LSBUI_STANDBY;
  end
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rstn) op <= lsbui_pkg::LSBUI_STANDBY;
    else       op <= next_op;
  end
  // -------------------------------------------------------------------------
  // registers and bus
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl     <= 32'h0000_0000;
      interval <= `LSBUI_RESET_INTERVAL;
      irq_mask <= '0;
    end else begin
      if (w_ctrl) ctrl <= {29'h0000_0000, avs_writedata[2:0]};
      if (w_int)  interval <= clamp_int;
      if (w_mask) irq_mask <= avs_writedata[`LSBUI_IRQ_W-1:0];
    end
  end
  // one wait cycle on an access, two on a back-to-back access, then accept
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      acc_d           <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !acc_d);
      acc_d           <= (avs_read || avs_write) && !avs_waitrequest;
      if ((avs_read || avs_write) && avs_waitrequest && !acc_d) avs_readdata <= rd_mux;
    end
  end
  // sticky status, set wins over write-one clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) irq_stat <= '0;
    else       irq_stat <= (irq_stat & ~(w_stat ? avs_writedata[`LSBUI_IRQ_W-1:0] : '0)) | ev;
  end
  // -------------------------------------------------------------------------
  // sampling timebase and log count
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || op == lsbui_pkg::LSBUI_STANDBY) begin
      sec_cnt <= 32'h0000_0000;
      int_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= tick_sec ? 32'h0000_0000 : sec_cnt + 32'd1;
      if (tick_sec) int_cnt <= tick_smp ? 32'h0000_0000 : int_cnt + 32'd1;
    end
  end
  // stored sample count, kept through sleep
  always_ff @(posedge clk_sys) begin
    if (!rstn || cmd_reset) nsamp <= 16'h0000;
    else if (do_sample && ctrl[`LSBUI_CTRL_STORE] && !mem_full) nsamp <= nsamp + 16'h0001;
  end
  // -------------------------------------------------------------------------
  // button sequencer
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bst        <= lsbui_pkg::LSBUI_B_REL;
      tmr        <= 32'h0000_0000;
      btn_q      <= 1'b0;
      offer_stop <= 1'b0;
    end else begin
      btn_q <= button;
      tmr   <= tmr + 32'd1;
      case (bst)
        lsbui_pkg::LSBUI_B_REL: if (press) begin
          bst <= lsbui_pkg::LSBUI_B_PRESS;
          tmr <= 32'h0000_0000;
        end
        lsbui_pkg::LSBUI_B_PRESS: begin
          if (release_e) bst <= lsbui_pkg::LSBUI_B_REL;
          else if (tmr >= 32'(SHORT_CYC - 1)) begin
            bst        <= long_ok ? lsbui_pkg::LSBUI_B_OFFER : lsbui_pkg::LSBUI_B_HELD;
            offer_stop <= op == lsbui_pkg::LSBUI_ACTIVE;
          end
        end
        lsbui_pkg::LSBUI_B_OFFER: if (release_e) begin
          bst <= lsbui_pkg::LSBUI_B_WAIT;
          tmr <= 32'h0000_0000;
        end
        lsbui_pkg::LSBUI_B_WAIT: begin
          if (confirm) bst <= lsbui_pkg::LSBUI_B_HELD;
          else if (tmr >= 32'(CONFIRM_CYC - 1)) bst <= lsbui_pkg::LSBUI_B_REL;
        end
        lsbui_pkg::LSBUI_B_HELD: if (!button) bst <= lsbui_pkg::LSBUI_B_REL;
        default: bst <= lsbui_pkg::LSBUI_B_REL;
      endcase
    end
  end
  // -------------------------------------------------------------------------
  // led display
  // -------------------------------------------------------------------------
  wire short_rel = bst == lsbui_pkg::LSBUI_B_PRESS && release_e;
  wire offer_on  = bst == lsbui_pkg::LSBUI_B_PRESS && tmr >= 32'(SHORT_CYC - 1) && long_ok;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lmode      <= lsbui_pkg::LSBUI_L_OFF;
      ltmr       <= 32'h0000_0000;
      snap_alarm <= 1'b0;
      snap_low   <= 1'b0;
    end else begin
      if (ltmr != 32'h0000_0000) ltmr <= ltmr - 32'd1;
      if (btn_start) begin
        lmode <= lsbui_pkg::LSBUI_L_ACK_S;
        ltmr  <= 32'(ACK_CYC);
      end else if (btn_stop) begin
        lmode <= lsbui_pkg::LSBUI_L_ACK_P;
        ltmr  <= 32'(ACK_CYC);
      end else if (offer_on) begin
        lmode <= op == lsbui_pkg::LSBUI_ACTIVE ? lsbui_pkg::LSBUI_L_OFFER_P
               : lsbui_pkg::LSBUI_L_OFFER_S;
        ltmr  <= 32'(CONFIRM_CYC);
      end else if (short_rel) begin
        lmode      <= lsbui_pkg::LSBUI_L_STATUS;
        ltmr       <= 32'(STATUS_CYC);
        snap_alarm <= any_alarm;
        snap_low   <= battery_low;
      end else if (bst == lsbui_pkg::LSBUI_B_REL && (lmode == lsbui_pkg::LSBUI_L_OFFER_S
                   || lmode == lsbui_pkg::LSBUI_L_OFFER_P)) begin
        lmode <= lsbui_pkg::LSBUI_L_OFF; // offer expired
      end else if (ltmr == 32'd1) begin
        lmode <= lsbui_pkg::LSBUI_L_OFF;
      end
    end
  end
  // blink divider
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'd1;
    end
  end
  // led drive
  logic ng, nr;
  always_comb begin
    ng = 1'b0;
    nr = 1'b0;
    case (lmode)
      lsbui_pkg::LSBUI_L_STATUS: begin
        ng = !snap_alarm && (!snap_low || blink);
        nr = snap_alarm && (!snap_low || blink);
      end
      lsbui_pkg::LSBUI_L_OFFER_S: begin
        ng = 1'b1;
        nr = blink;
      end
      lsbui_pkg::LSBUI_L_OFFER_P: begin
        nr = 1'b1;
        ng = blink;
      end
      lsbui_pkg::LSBUI_L_ACK_S: ng = 1'b1;
      lsbui_pkg::LSBUI_L_ACK_P: nr = 1'b1;
      default: begin
        ng = 1'b0;
        nr = 1'b0;
      end
    endcase
  end
  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      led_green    <= 1'b0;
      led_red      <= 1'b0;
      clock_run    <= 1'b0;
      sample_take  <= 1'b0;
      sample_store <= 1'b0;
      op_state     <= 2'b00;
      irq          <= 1'b0;
    end else begin
      led_green    <= ng;
      led_red      <= nr;
      clock_run    <= op != lsbui_pkg::LSBUI_STANDBY;
      sample_take  <= do_sample;
      sample_store <= do_sample && ctrl[`LSBUI_CTRL_STORE] && !mem_full;
      op_state     <= op;
      irq          <= |(irq_stat & irq_mask);
    end
  end
endmodule
`default_nettype wire

// [hw/lsbui_defines.svh]
`ifndef LSBUI_DEFINES_SVH
`define LSBUI_DEFINES_SVH
// ---------------------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------------------
`define LSBUI_CLK_HZ          20000000
`define LSBUI_SHORT_MS        2000
`define LSBUI_STATUS_MS       2000
`define LSBUI_CONFIRM_MS      5000
`define LSBUI_ACK_MS          15000
`define LSBUI_BLINK_MS        250
`define LSBUI_MS_CYC          (`LSBUI_CLK_HZ / 1000)
// ---------------------------------------------------------------------------
// limits
// ---------------------------------------------------------------------------
`define LSBUI_INTERVAL_MIN_S  1
`define LSBUI_INTERVAL_MAX_S  64800
`define LSBUI_LOG_DEPTH       3958
`define LSBUI_NUM_RANGES      16
// ---------------------------------------------------------------------------
// register word offsets (word index, avs_address[5:2])
// ---------------------------------------------------------------------------
`define LSBUI_REG_CTRL        4'h0
`define LSBUI_REG_STATE       4'h1
`define LSBUI_REG_INTERVAL    4'h2
`define LSBUI_REG_COUNT       4'h3
`define LSBUI_REG_IRQ_STAT    4'h4
`define LSBUI_REG_IRQ_MASK    4'h5
`define LSBUI_REG_RANGE_ALM   4'h6
`define LSBUI_REG_CMD         4'h7
// ---------------------------------------------------------------------------
// control fields
// ---------------------------------------------------------------------------
`define LSBUI_CTRL_BSE        0
`define LSBUI_CTRL_STOPDIS    1
`define LSBUI_CTRL_STORE      2
`define LSBUI_CMD_START       0
`define LSBUI_CMD_STOP        1
`define LSBUI_CMD_RESET       2
// ---------------------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------------------
`define LSBUI_IRQ_STARTED     0
`define LSBUI_IRQ_STOPPED     1
`define LSBUI_IRQ_SAMPLE      2
`define LSBUI_IRQ_FULL        3
`define LSBUI_IRQ_W           4
`define LSBUI_RESET_INTERVAL  32'h0000_003c
`endif

// [hw/lsbui_pkg.sv]
package lsbui_pkg;
  // operating states of the tag
  typedef enum logic [1:0] {
    LSBUI_STANDBY = 2'b00,
    LSBUI_IDLE    = 2'b01,
    LSBUI_ACTIVE  = 2'b10,
    LSBUI_SLEEP   = 2'b11
  } lsbui_op_t;
  // button interface phases
  typedef enum logic [2:0] {
    LSBUI_B_REL     = 3'b000,
    LSBUI_B_PRESS   = 3'b001,
    LSBUI_B_OFFER   = 3'b010,
    LSBUI_B_WAIT    = 3'b011,
    LSBUI_B_HELD    = 3'b100,
    LSBUI_B_SHOW    = 3'b101
  } lsbui_btn_t;
  // what the leds are currently showing
  typedef enum logic [2:0] {
    LSBUI_L_OFF     = 3'b000,
    LSBUI_L_STATUS  = 3'b001,
    LSBUI_L_OFFER_S = 3'b010,
    LSBUI_L_OFFER_P = 3'b011,
    LSBUI_L_ACK_S   = 3'b100,
    LSBUI_L_ACK_P   = 3'b101
  } lsbui_led_t;
endpackage

// [bench/lsbui_core_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the logger control
// ----------------------------------------
module lsbui_core_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // bus and reader
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       reader_reset,
  // logging side
  input wire logic       clock_run,
  input wire logic       sample_take,
  input wire logic       sample_store,
  input wire logic [1:0] op_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // bus answers one cycle after a request rises, for one cycle only
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // clock halted in stand-by, running elsewhere
  chk_standby_halt: assert property ((op_state == 2'h0) [*2] |-> !clock_run)
    else $error("clock runs in stand-by");
  chk_run_outside: assert property ((op_state != 2'h0) [*2] |-> clock_run)
    else $error("clock halted outside stand-by");
  // samples only while logging, stores tied to a sample
  chk_sample_active: assert property (sample_take |-> op_state == 2'h2 || $past(op_state) == 2'h2)
    else $error("sample taken outside active");
  chk_store_pairs: assert property (sample_store |-> sample_take || $past(sample_take))
    else $error("store without a sample");
  // legal state order
  chk_idle_entry: assert property (op_state == 2'h1 && $past(op_state) != 2'h1
    |-> $past(op_state) == 2'h0)
    else $error("idle entered from a state other than stand-by");
  chk_active_entry: assert property (op_state == 2'h2 && $past(op_state) != 2'h2
    |-> $past(op_state) == 2'h1)
    else $error("active entered from a state other than idle");
  chk_sleep_entry: assert property (op_state == 2'h3 && $past(op_state) != 2'h3
    |-> $past(op_state) == 2'h2)
    else $error("sleep entered from a state other than active");
  chk_sleep_exit: assert property ($fell(op_state == 2'h3) |-> $past(reader_reset)
    || $past(reader_reset, 2) || $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("sleep left without a reset command");
endmodule
`default_nettype wire

// [bench/lsbui_operator.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// button operator: press, optional repress
// ----------------------------------------
module lsbui_operator (
  // clock
  input  wire logic        clk_sys,
  // request from the bench
  input  wire logic        go,
  input  wire logic [15:0] hold,
  input  wire logic [15:0] gap,
  input  wire logic        again,
  // to the tag, and busy back to the bench
  output logic             button,
  output logic             busy
);
  // hold for hold cycles, then confirm after gap when asked
  initial begin
    button = 1'h0;
    busy = 1'h0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        busy <= 1'h1;
        button <= 1'h1;
        repeat (hold) @(posedge clk_sys);
        button <= 1'h0;
        if (again) begin
          repeat (gap) @(posedge clk_sys);
          button <= 1'h1;
          repeat (4) @(posedge clk_sys);
          button <= 1'h0;
        end
        @(posedge clk_sys);
        busy <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/lsbui_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module lsbui_core_tb_top;
  // short counts: hold, status, confirm, ack, second, log depth
  localparam int SH = 20, ST = 20, CF = 50, AK = 150, SC = 10, LD = 8;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_sys = 1'h0;
  logic        rstn = 1'h0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, button, led_green, led_red, irq, busy;
  logic        clock_run, sample_take, sample_store;
  logic [1:0]  op_state;
  logic [4:0]  alm = 5'h00;            // five single alarm flags
  logic [15:0] range_alarm = 16'h0000;
  logic        battery_low = 1'h0, reader_start = 1'h0, reader_reset = 1'h0;
  logic        go = 1'h0, again = 1'h0;
  logic [15:0] hold = 16'h0000, gap = 16'h0000;
  int          fails = 0, checks = 0, exp_op = 0, ng, nr, tg, tr, n, k;
  always #25 clk_sys = ~clk_sys;
  lsbui_core #(.SHORT_CYC(SH), .STATUS_CYC(ST), .CONFIRM_CYC(CF), .ACK_CYC(AK),
    .BLINK_CYC(3), .SEC_CYC(SC), .LOG_DEPTH(LD)) lsbui_core_i (.clk_sys, .rstn,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .button, .led_green, .led_red,
    .memory_full_flag(alm[0]), .arrival_time_alarm(alm[1]), .bin_counter_alarm(alm[2]),
    .kinetic_temp_alarm(alm[3]), .shelf_life_alarm(alm[4]), .range_alarm, .battery_low,
    .reader_start, .reader_reset, .clock_run, .sample_take, .sample_store, .op_state, .irq);
  lsbui_operator lsbui_operator_i (.clk_sys, .go, .hold, .gap, .again, .button, .busy);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 50, 1, "bus timeout");
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask
  // hand a press to the operator and wait for it to finish
  task press(input int h, input logic a);
    hold <= h[15:0];
    gap <= 16'h000a;
    again <= a;
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy === 1'h1 && n < 2000);
  endtask
  // count lit cycles and toggles of both leds
  task watch(input int c);
    logic pg;
    logic pr;
    pg = led_green;
    pr = led_red;
    {ng, nr, tg, tr} = '0;
    repeat (c) begin
      @(posedge clk_sys);
      ng += int'(led_green === 1'h1);
      nr += int'(led_red === 1'h1);
      tg += int'(led_green !== pg);
      tr += int'(led_red !== pr);
      pg = led_green;
      pr = led_red;
    end
  endtask
  // long press with the offer indication looked at mid-hold
  task offer(input logic stop, input logic a);
    fork
      press(2 * SH, a);
      begin
        cyc(SH + 8);
        watch(8);
        chk(stop ? (nr == 8 && tg > 0) : (ng == 8 && tr > 0), 1, "offer leds");
      end
    join
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog far beyond the expected run of under fifteen hundred cycles
  initial begin
    cyc(20000);
    chk(0, 1, "watchdog");
    close_out;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(88784));
    cyc(8);
    rstn <= 1'h1;
    cyc(1);
    chk({op_state, clock_run, led_green, led_red, avs_waitrequest}, 1, "reset state");
    bus(0, 6'h08, 0);
    chk(q, 32'h0000_003c, "interval reset");
    bus(1, 6'h08, 32'h0000_0000);
    bus(0, 6'h08, 0);
    chk(q, 32'h0000_0001, "interval low clamp");
    bus(1, 6'h08, 32'h0001_0000);
    bus(0, 6'h08, 0);
    chk(q, 32'h0000_fd20, "interval high clamp");
    bus(1, 6'h20, 32'hffff_ffff);
    bus(0, 6'h20, 0);
    chk(q, 0, "unmapped read");
    $display("test registers done");
    reader_start <= 1'h1;
    cyc(1);
    reader_start <= 1'h0;
    cyc(3);
    exp_op = 1;
    chk({op_state, clock_run}, {exp_op[1:0], 1'h1}, "idle entry");
    // status table: alarm and battery combinations, random source
    for (int i = 0; i < 4; i++) begin
      k = $urandom_range(5);
      range_alarm <= (i[0] && k == 5) ? 16'h0001 << $urandom_range(15) : 16'h0000;
      alm <= (i[0] && k < 5) ? 5'h01 << k : 5'h00;
      battery_low <= i[1];
      cyc(2);
      press(5, 0);
      cyc(1);
      watch(14);
      if (i[1])
        chk(i[0] ? (ng == 0 && tr > 1) : (nr == 0 && tg > 1), 1, "blink status");
      else
        chk(i[0] ? (ng == 0 && nr == 14) : (nr == 0 && ng == 14), 1, "steady");
      bus(0, 6'h18, 0);
      chk(q, {16'h0000, range_alarm}, "range alarms");
      cyc(ST);
    end
    alm <= 5'h00;
    range_alarm <= 16'h0000;
    battery_low <= 1'h0;
    $display("test status done");
    press(2 * SH, 1);
    cyc(ST + 10);
    chk(op_state, exp_op, "start with enable clear");
    bus(1, 6'h00, 1);
    bus(1, 6'h14, 1);
    offer(0, 0);
    cyc(CF + 20);
    chk(op_state, exp_op, "unconfirmed start");
    offer(0, 1);
    cyc(2);
    exp_op = 2;
    chk(op_state, exp_op, "button start");
    watch(100);
    chk(ng, 100, "start ack green");
    chk(irq, 1, "irq raised");
    bus(1, 6'h14, 0);
    cyc(2);
    chk(irq, 0, "irq masked");
    bus(1, 6'h14, 1);
    bus(1, 6'h10, 1);
    cyc(2);
    chk(irq, 0, "irq cleared");
    cyc(AK);
    bus(1, 6'h08, 1);
    cyc(5);
    k = 0;
    repeat (100) begin
      @(posedge clk_sys);
      k += int'(sample_take === 1'h1);
    end
    chk(k >= 9 && k <= 11, 1, "one sample a second");
    $display("test start done");
    bus(1, 6'h00, 3);
    press(2 * SH, 1);
    cyc(ST + 10);
    chk(op_state, exp_op, "stop disabled");
    bus(1, 6'h00, 1);
    offer(1, 1);
    cyc(2);
    exp_op = 3;
    chk(op_state, exp_op, "button stop");
    watch(100);
    chk(nr, 100, "stop ack red");
    cyc(AK);
    chk(op_state, exp_op, "sleep kept");
    bus(1, 6'h1c, 4);
    cyc(3);
    exp_op = 0;
    chk(op_state, exp_op, "reset command");
    $display("test stop done");
    bus(1, 6'h00, 5);
    bus(1, 6'h08, 1);
    bus(1, 6'h1c, 1);
    reader_start <= 1'h1;
    cyc(1);
    reader_start <= 1'h0;
    cyc(3);
    k = 0;
    repeat (LD * SC + 40) begin
      @(posedge clk_sys);
      k += int'(sample_store === 1'h1);
    end
    exp_op = 3;
    chk(op_state, exp_op, "full log ends logging");
    chk(k, LD, "stored samples");
    bus(0, 6'h0c, 0);
    chk(q, LD, "stored count");
    reader_reset <= 1'h1;
    cyc(1);
    reader_reset <= 1'h0;
    cyc(3);
    chk({op_state, clock_run}, 0, "reader reset");
    $display("test log done");
    close_out;
  end
endmodule
bind lsbui_core lsbui_core_props lsbui_core_props_i (.clk_sys, .rstn, .avs_read,
  .avs_write, .avs_waitrequest, .reader_reset, .clock_run, .sample_take, .sample_store,
  .op_state);
`default_nettype wire
